//--- hdl/tcit_top.sv
// Purpose: three-counter interval timer behind four byte ports
// Assumes: bus strobes and pins synchronous to I_CLK_SYS
// Notes: counter 2 output is the pacer trigger and irq source
`timescale 1ns/10ps
`include "tcit_cfg.svh"
module tcit_top
  import tcit_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CS,
  input wire logic [1:0] I_ADDR,
  input wire logic I_IOW,
  input wire logic I_IOR,
  input wire logic [7:0] I_DATA_IN,
  input wire logic I_C0_CLK_EXT,
  input wire logic I_C0_CLK_SEL,
  input wire logic I_C0_GATE,
  input wire logic I_C1_GATE,
  input wire logic I_C1_GATE_DRV,
  input wire logic I_C2_GATE,
  input wire logic I_C2_GATE_DRV,
  output logic [7:0] O_DATA_OUT,
  output logic O_DATA_OE,
  output logic O_C0_OUT,
  output logic O_PACER_TRIG,
  output logic O_TIMER_IRQ
);
  // ==========================================================
  // state types
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cr;
    logic [15:0] ol;
    logic [7:0] tmp_lsb;
    tcit_mode_t mode;
    tcit_acc_t acc;
    logic bcd;
    logic latched;
    logic rd_hi;
    logic wr_hi;
    logic out;
    logic reload_pend;
    tcit_phase_t phase;
  } tcit_ctr_t;

  typedef struct packed {
    tcit_ctr_t [`TCIT_NCTR-1:0] ctr;
    logic [7:0] rdata;
    logic oe;
  } tcit_st_t;

  tcit_st_t s_r;
  tcit_st_t s_nxt;
  tcit_evt_if ev ();

  // ==========================================================
  // helpers
  function automatic logic [15:0] cnt_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic brw;
    r = v;
    brw = 1'b1;
    if (!bcd) begin
      r = v - `TCIT_CNT_ONE;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (brw) begin
          if (v[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = `TCIT_BCD_DIGIT_MAX;
          end else begin
            r[4*k +: 4] = v[4*k +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  function automatic tcit_mode_t norm_mode(input logic [2:0] m);
    tcit_mode_t r;
    r = tcit_mode_t'(m);
    if (m[1]) begin
      r = tcit_mode_t'({1'b0, m[1:0]});
    end
    return r;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
    logic [7:0] r;
    r = hi ? v[15:8] : v[7:0];
    return r;
  endfunction

  // ==========================================================
  // helpers instances
  tcit_tick u_tick (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .ev(ev.gen)
  );

  tcit_edge u_edge (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .ev(ev.edg)
  );

  // ==========================================================
  // event levels
  logic [`TCIT_NCTR-1:0] gate;

  assign gate[0] = I_C0_GATE;
  assign gate[1] = I_C1_GATE_DRV ? I_C1_GATE : 1'b1;
  assign gate[2] = I_C2_GATE_DRV ? I_C2_GATE : 1'b1;
  assign ev.lvl[`TCIT_EV_C0CLK] = I_C0_CLK_EXT;
  assign ev.lvl[`TCIT_EV_G0] = gate[0];
  assign ev.lvl[`TCIT_EV_G1] = gate[1];
  assign ev.lvl[`TCIT_EV_G2] = gate[2];
  assign ev.lvl[`TCIT_EV_C1OUT] = s_r.ctr[1].out;

  // ==========================================================
  // next state
  always_comb begin
    tcit_ctr_t c;
    logic clk_ev;
    logic g;
    logic gr;
    logic load;
    logic [1:0] sel;
    c = '0;
    clk_ev = 1'b0;
    g = 1'b0;
    gr = 1'b0;
    load = 1'b0;
    sel = I_DATA_IN[`TCIT_CB_SEL];
    s_nxt = s_r;
    s_nxt.oe = 1'b0;

    // counting, one engine per counter
    for (int i = 0; i < `TCIT_NCTR; i++) begin
      c = s_r.ctr[i];
      if (i == 0) begin
        clk_ev = I_C0_CLK_SEL ? ev.rise[`TCIT_EV_C0CLK] : ev.tick_2m;
        gr = ev.rise[`TCIT_EV_G0];
      end else if (i == 1) begin
        clk_ev = ev.tick_2m;
        gr = ev.rise[`TCIT_EV_G1];
      end else begin
        clk_ev = ev.rise[`TCIT_EV_C1OUT];
        gr = ev.rise[`TCIT_EV_G2];
      end
      g = gate[i];

      if (c.phase != PH_IDLE && gr) begin
        if (c.mode != MD_TC_IRQ && c.mode != MD_SW_STROBE) begin
          c.reload_pend = 1'b1;
        end
      end
      if ((c.mode == MD_RATE || c.mode == MD_SQUARE) && !g) begin
        c.out = 1'b1;
      end

      if (clk_ev) begin
        if (c.reload_pend) begin
          c.cnt = c.cr;
          c.reload_pend = 1'b0;
          c.phase = PH_RUN;
          if (c.mode == MD_ONESHOT) begin
            c.out = 1'b0;
          end
        end else if (c.phase == PH_RUN) begin
          case (c.mode)
            MD_TC_IRQ: begin
              if (g) begin
                if (c.cnt == `TCIT_CNT_ONE) begin
                  c.out = 1'b1;
                  c.phase = PH_DONE;
                end
                c.cnt = cnt_dec(c.cnt, c.bcd);
              end
            end
            MD_ONESHOT: begin
              if (c.cnt == `TCIT_CNT_ONE) begin
                c.out = 1'b1;
                c.phase = PH_DONE;
              end
              c.cnt = cnt_dec(c.cnt, c.bcd);
            end
            MD_RATE: begin
              if (g) begin
                if (c.cnt == `TCIT_CNT_TWO) begin
                  c.out = 1'b0;
                end
                if (c.cnt == `TCIT_CNT_ONE) begin
                  c.out = 1'b1;
                  c.cnt = c.cr;
                end else begin
                  c.cnt = cnt_dec(c.cnt, c.bcd);
                end
              end
            end
            MD_SQUARE: begin
              if (g) begin
                if (c.cnt == `TCIT_CNT_TWO || c.cnt == `TCIT_CNT_ONE) begin
                  c.out = ~c.out;
                  c.cnt = c.cr;
                end else begin
                  c.cnt = cnt_dec(cnt_dec(c.cnt, c.bcd), c.bcd);
                end
              end
            end
            MD_SW_STROBE, MD_HW_STROBE: begin
              if (g || c.mode == MD_HW_STROBE) begin
                c.cnt = cnt_dec(c.cnt, c.bcd);
                if (c.cnt == `TCIT_CNT_ONE) begin
                  c.phase = PH_DONE;
                end
              end
            end
            default: begin
              c.cnt = cnt_dec(c.cnt, c.bcd);
            end
          endcase
        end else if (c.phase == PH_DONE) begin
          if ((c.mode == MD_SW_STROBE || c.mode == MD_HW_STROBE) && c.cnt == `TCIT_CNT_ONE) begin
            c.out = 1'b0;
          end else begin
            c.out = (c.mode == MD_SW_STROBE || c.mode == MD_HW_STROBE) ? 1'b1 : c.out;
          end
          if (g || c.mode != MD_TC_IRQ) begin
            c.cnt = cnt_dec(c.cnt, c.bcd);
          end
        end
      end
      s_nxt.ctr[i] = c;
    end

    // bus writes, after counting so a write wins
    if (I_CS && I_IOW) begin
      if (I_ADDR == `TCIT_OFS_CTRL) begin
        if (sel != `TCIT_SEL_ILLEGAL) begin
          c = s_nxt.ctr[sel];
          if (tcit_acc_t'(I_DATA_IN[`TCIT_CB_ACC]) == AC_LATCH) begin
            if (!c.latched) begin
              c.ol = s_r.ctr[sel].cnt;
              c.latched = 1'b1;
            end
          end else begin
            c.acc = tcit_acc_t'(I_DATA_IN[`TCIT_CB_ACC]);
            c.mode = norm_mode(I_DATA_IN[`TCIT_CB_MODE]);
            c.bcd = I_DATA_IN[`TCIT_CB_BCD];
            c.latched = 1'b0;
            c.rd_hi = 1'b0;
            c.wr_hi = 1'b0;
            c.phase = PH_IDLE;
            c.reload_pend = 1'b0;
            c.out = (c.mode != MD_TC_IRQ);
          end
          s_nxt.ctr[sel] = c;
        end
      end else begin
        c = s_nxt.ctr[I_ADDR];
        load = 1'b0;
        if (c.acc == AC_LSB) begin
          c.cr = {8'h00, I_DATA_IN};
          load = 1'b1;
        end else if (c.acc == AC_MSB) begin
          c.cr = {I_DATA_IN, 8'h00};
          load = 1'b1;
        end else if (c.acc == AC_BOTH) begin
          if (!c.wr_hi) begin
            c.tmp_lsb = I_DATA_IN;
            c.wr_hi = 1'b1;
            if (c.mode == MD_TC_IRQ) begin
              c.out = 1'b0;
              c.phase = PH_ARMED;
              c.reload_pend = 1'b0;
            end
          end else begin
            c.cr = {I_DATA_IN, c.tmp_lsb};
            c.wr_hi = 1'b0;
            load = 1'b1;
          end
        end
        if (load) begin
          c.phase = PH_ARMED;
          c.reload_pend = (c.mode != MD_ONESHOT && c.mode != MD_HW_STROBE);
          if (c.mode == MD_TC_IRQ) begin
            c.out = 1'b0;
          end
        end
        s_nxt.ctr[I_ADDR] = c;
      end
    end

    // bus reads
    if (I_CS && I_IOR) begin
      s_nxt.oe = 1'b1;
      s_nxt.rdata = `TCIT_READ_IDLE;
      if (I_ADDR != `TCIT_OFS_CTRL) begin
        c = s_nxt.ctr[I_ADDR];
        if (c.acc == AC_MSB) begin
          s_nxt.rdata = pick_byte(c.latched ? c.ol : s_r.ctr[I_ADDR].cnt, 1'b1);
          c.latched = 1'b0;
        end else if (c.acc == AC_LSB) begin
          s_nxt.rdata = pick_byte(c.latched ? c.ol : s_r.ctr[I_ADDR].cnt, 1'b0);
          c.latched = 1'b0;
        end else begin
          s_nxt.rdata = pick_byte(c.latched ? c.ol : s_r.ctr[I_ADDR].cnt, c.rd_hi);
          if (c.rd_hi) begin
            c.latched = 1'b0;
          end
          c.rd_hi = ~c.rd_hi;
        end
        s_nxt.ctr[I_ADDR] = c;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign O_DATA_OUT = s_r.rdata;
  assign O_DATA_OE = s_r.oe;
  assign O_C0_OUT = s_r.ctr[0].out;
  assign O_PACER_TRIG = s_r.ctr[2].out;
  assign O_TIMER_IRQ = s_r.ctr[2].out;
endmodule

//--- hdl/tcit_cfg.svh
// Purpose: constants of the three-counter interval timer
// Assumes: included by interface and design modules
// Notes: definitions only
`ifndef TCIT_CFG_SVH
`define TCIT_CFG_SVH

// ==========================================================
// port offsets from the card base
`define TCIT_OFS_CNT0 2'h0
`define TCIT_OFS_CNT1 2'h1
`define TCIT_OFS_CNT2 2'h2
`define TCIT_OFS_CTRL 2'h3

// ==========================================================
// control byte fields
`define TCIT_CB_SEL 7:6
`define TCIT_CB_ACC 5:4
`define TCIT_CB_MODE 3:1
`define TCIT_CB_BCD 0
`define TCIT_SEL_ILLEGAL 2'h3
`define TCIT_NCTR 3

// ==========================================================
// clocks, in kHz, and the tick accumulator width in bits
`define TCIT_CLK_KHZ 25000
`define TCIT_PACER_KHZ 2000
`define TCIT_ACC_W 15

// ==========================================================
// event lines watched for edges
`define TCIT_EV_C0CLK 0
`define TCIT_EV_G0 1
`define TCIT_EV_G1 2
`define TCIT_EV_G2 3
`define TCIT_EV_C1OUT 4
`define TCIT_NEV 5

// ==========================================================
// counting values
`define TCIT_CNT_ONE 16'h0001
`define TCIT_CNT_TWO 16'h0002
`define TCIT_BCD_DIGIT_MAX 4'h9
`define TCIT_READ_IDLE 8'h00

`endif

//--- hdl/tcit_pkg.sv
// Purpose: types of the three-counter interval timer
// Assumes: tcit_cfg.svh holds the numbers
// Notes: enums of modes, access patterns and counter phases
package tcit_pkg;
  // ==========================================================
  // operating modes
  typedef enum logic [2:0] {
    MD_TC_IRQ = 3'h0,
    MD_ONESHOT = 3'h1,
    MD_RATE = 3'h2,
    MD_SQUARE = 3'h3,
    MD_SW_STROBE = 3'h4,
    MD_HW_STROBE = 3'h5
  } tcit_mode_t;

  // ==========================================================
  // access patterns
  typedef enum logic [1:0] {
    AC_LATCH = 2'h0,
    AC_LSB = 2'h1,
    AC_MSB = 2'h2,
    AC_BOTH = 2'h3
  } tcit_acc_t;

  // ==========================================================
  // counter phase, gray coded
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ARMED = 2'h1,
    PH_RUN = 2'h3,
    PH_DONE = 2'h2
  } tcit_phase_t;
endpackage

//--- hdl/tcit_evt_if.sv
// Purpose: event carrier between timer core and helpers
// Assumes: one clock domain
// Notes: lvl in, rise out, plus the 2 MHz tick
`timescale 1ns/10ps
`include "tcit_cfg.svh"
interface tcit_evt_if;
  logic tick_2m;
  logic [`TCIT_NEV-1:0] lvl;
  logic [`TCIT_NEV-1:0] rise;
  modport gen (output tick_2m);
  modport edg (input lvl, output rise);
  modport core (input tick_2m, input rise, output lvl);
endinterface

//--- hdl/tcit_tick.sv
// Purpose: 2 MHz count tick from the system clock
// Assumes: OUT_KHZ below CLK_KHZ
// Notes: fractional accumulator, mean rate exact
`timescale 1ns/10ps
`include "tcit_cfg.svh"
module tcit_tick #(
  parameter int CLK_KHZ = `TCIT_CLK_KHZ,
  parameter int OUT_KHZ = `TCIT_PACER_KHZ,
  parameter int ACC_W = `TCIT_ACC_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  tcit_evt_if.gen ev
);
  localparam logic [ACC_W:0] STEP = (ACC_W+1)'(OUT_KHZ);
  localparam logic [ACC_W:0] LIM = (ACC_W+1)'(CLK_KHZ);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } tcit_tick_st_t;

  tcit_tick_st_t s_r;
  tcit_tick_st_t s_nxt;
  logic [ACC_W:0] sum;

  always_comb begin
    s_nxt = s_r;
    sum = {1'b0, s_r.acc} + STEP;
    s_nxt.tick = 1'b0;
    if (sum >= LIM) begin
      sum = sum - LIM;
      s_nxt.tick = 1'b1;
    end
    s_nxt.acc = sum[ACC_W-1:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ev.tick_2m = s_r.tick;
endmodule

//--- hdl/tcit_edge.sv
// Purpose: rising edge pulses of clock, gate and cascade lines
// Assumes: levels synchronous to the system clock
// Notes: one-cycle pulse per rising edge
`timescale 1ns/10ps
`include "tcit_cfg.svh"
module tcit_edge (
  input wire logic i_clk,
  input wire logic i_rst_n,
  tcit_evt_if.edg ev
);
  typedef struct packed {
    logic [`TCIT_NEV-1:0] prev;
    logic live;
  } tcit_edge_st_t;

  tcit_edge_st_t s_r;
  tcit_edge_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = ev.lvl;
    s_nxt.live = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // no pulses until prev holds real pin levels, so pulled-up gates give no false edge
  assign ev.rise = ev.lvl & ~s_r.prev & {`TCIT_NEV{s_r.live}};
endmodule

//--- verification/tcit_assertions.sv
// Purpose: port checks of the interval timer
// Assumes: sees only the top ports
// Notes: bound from the bench top
`timescale 1ns/10ps
module tcit_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CS,
  input wire logic [1:0] I_ADDR,
  input wire logic I_IOR,
  input wire logic [7:0] O_DATA_OUT,
  input wire logic O_DATA_OE,
  input wire logic O_C0_OUT,
  input wire logic O_PACER_TRIG,
  input wire logic O_TIMER_IRQ
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);
  logic rd;
  assign rd = I_CS && I_IOR;
  // ==========================================================
  // bus answer and pacer shape
  read_answer_a: assert property (rd |=> O_DATA_OE)
    else $error("no enable after read");
  enable_quiet_a: assert property (!rd |=> !O_DATA_OE)
    else $error("enable without read");
  ctrl_read_a: assert property (rd && I_ADDR == 2'h3 |=> O_DATA_OUT == 8'h00)
    else $error("control port read not zero");
  data_hold_a: assert property (!rd |=> $stable(O_DATA_OUT))
    else $error("read data moved");
  irq_source_a: assert property (O_TIMER_IRQ == O_PACER_TRIG)
    else $error("irq differs from pacer");
  trig_low_a: assert property ($fell(O_PACER_TRIG) |=> !O_PACER_TRIG [*8])
    else $error("pacer low too short");
  trig_high_a: assert property ($rose(O_PACER_TRIG) |=> O_PACER_TRIG [*8])
    else $error("pacer high too short");
  rst_quiet_a: assert property ($rose(I_RST_N) |-> !(O_DATA_OE || O_PACER_TRIG || O_C0_OUT))
    else $error("outputs set after reset");
endmodule

//--- verification/tcit_host.sv
// Purpose: host model driving the timer byte ports
// Assumes: strobes set and cleared at falling edges
// Notes: released lines show the inverse of the last value
`timescale 1ns/10ps
module tcit_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_cs,
  output logic [1:0] o_addr,
  output logic o_iow,
  output logic o_ior,
  output logic [7:0] o_wdata
);
  // ==========================================================
  // one strobe cycle per access
  initial begin
    o_cs = 1'b0;
    o_addr = 2'h0;
    o_iow = 1'b0;
    o_ior = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge i_clk);
    o_cs = 1'b1;
    o_addr = a;
    o_wdata = d;
    o_iow = w;
    o_ior = !w;
    @(negedge i_clk);
    q = i_rdata;
    o_cs = 1'b0;
    o_iow = 1'b0;
    o_ior = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

//--- verification/tb_top.sv
// Purpose: self-checking bench of the interval timer
// Assumes: host model drives the byte ports
// Notes: counter 0 runs off bench pulses for exact counts, and off the 2 MHz tick in the pacer test
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, cs, iow, ior, c0_ext, c0_sel, g0, g1, g1d, g2, g2d;
  logic oe, c0_out, trig, irq;
  logic [1:0] addr;
  logic [7:0] wd, rdo, q;
  int err_count, checked, cyc, nc, nt;
  logic [7:0] mctl [6] = '{8'h30, 8'h32, 8'h3C, 8'h3E, 8'h38, 8'h3A};
  int mlow [6] = '{3, 3, 4, 6, 1, 1};
  tcit_top tcit_top_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CS(cs), .I_ADDR(addr),
    .I_IOW(iow), .I_IOR(ior), .I_DATA_IN(wd), .I_C0_CLK_EXT(c0_ext), .I_C0_CLK_SEL(c0_sel),
    .I_C0_GATE(g0), .I_C1_GATE(g1), .I_C1_GATE_DRV(g1d), .I_C2_GATE(g2),
    .I_C2_GATE_DRV(g2d), .O_DATA_OUT(rdo), .O_DATA_OE(oe), .O_C0_OUT(c0_out),
    .O_PACER_TRIG(trig), .O_TIMER_IRQ(irq));
  tcit_host tcit_host_inst (.i_clk(clk), .i_rdata(rdo), .o_cs(cs), .o_addr(addr),
    .o_iow(iow), .o_ior(ior), .o_wdata(wd));
  // ==========================================================
  // compares, bus calls and helpers
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    tcit_host_inst.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    tcit_host_inst.acc(1'b0, a, 8'h00, q);
    chk_byte(q, exp);
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge clk) c0_ext = 1'b1;
      repeat (3) @(negedge clk);
      c0_ext = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic falls(input int n);
    logic pt, pc;
    nt = 0;
    nc = 0;
    pt = trig;
    pc = c0_out;
    repeat (n) begin
      @(negedge clk);
      if (pt && !trig) nt++;
      if (pc && !c0_out) nc++;
      pt = trig;
      pc = c0_out;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end
  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    c0_ext = 1'b0;
    c0_sel = 1'b1;
    g0 = 1'b0;
    g1 = 1'b0;
    g1d = 1'b0;
    g2 = 1'b0;
    g2d = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(2'h3, 8'h00);
    $display("decode test done");
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h5A);
    pulse(1);
    wr(2'h3, 8'h00);
    rd(2'h0, 8'h5A);
    wr(2'h3, 8'h20);
    wr(2'h0, 8'h12);
    pulse(1);
    rd(2'h0, 8'h12);
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h77);
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    pulse(1);
    wr(2'h3, 8'h00);
    g0 = 1'b1;
    pulse(3);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    rd(2'h0, 8'h31);
    rd(2'h0, 8'h12);
    $display("access test done");
    for (int b = 0; b < 2; b++) begin
      wr(2'h3, {7'h18, b[0]});
      wr(2'h0, 8'h01);
      wr(2'h0, 8'h00);
      pulse(1);
      chk_byte({7'h00, c0_out}, 8'h00);
      pulse(3);
      chk_byte({7'h00, c0_out}, 8'h01);
      wr(2'h3, 8'hD0);
      wr(2'h3, 8'h00);
      rd(2'h0, b ? 8'h98 : 8'hFE);
      rd(2'h0, b ? 8'h99 : 8'hFF);
    end
    $display("format test done");
    for (int m = 0; m < 6; m++) begin
      g0 = 1'b0;
      wr(2'h3, mctl[m]);
      wr(2'h0, (m == 3) ? 8'h04 : 8'h03);
      wr(2'h0, 8'h00);
      g0 = 1'b1;
      nc = 0;
      repeat (12) begin
        pulse(1);
        if (c0_out === 1'b0) nc++;
      end
      chk_num(nc, mlow[m]);
    end
    $display("mode test done");
    c0_sel = 1'b0;
    wr(2'h3, 8'h14);
    wr(2'h0, 8'h02);
    wr(2'h3, 8'h74);
    wr(2'h1, 8'h02);
    wr(2'h1, 8'h00);
    wr(2'h3, 8'hB4);
    wr(2'h2, 8'h02);
    wr(2'h2, 8'h00);
    falls(200);
    falls(1000);
    chk_num(nt, 20);
    chk_num(nc, 40);
    g2d = 1'b1;
    g2 = 1'b1;
    g1d = 1'b1;
    falls(100);
    falls(500);
    chk_num(nt, 0);
    g1d = 1'b0;
    falls(200);
    falls(1000);
    chk_num(nt, 20);
    $display("pacer test done");
    wrap_up();
  end
endmodule

bind tcit_top tcit_assertions tcit_assertions_inst (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
  .I_CS(I_CS), .I_ADDR(I_ADDR), .I_IOR(I_IOR), .O_DATA_OUT(O_DATA_OUT), .O_DATA_OE(O_DATA_OE),
  .O_C0_OUT(O_C0_OUT), .O_PACER_TRIG(O_PACER_TRIG), .O_TIMER_IRQ(O_TIMER_IRQ));
